// [verilog/scdec_pkg.sv]
// Constants, opcodes, status codes and register map of the command block decoder.
// Assumes a single 250 MHz clock shared by both ends of the link.
package scdec_pkg;
	typedef logic [7:0] scdec_byte_t;

	localparam int          CDB_MAX       = 10;
	localparam logic [3:0]  CDB_LEN_G0    = 4'h6;
	localparam logic [3:0]  CDB_LEN_G1    = 4'ha;
	localparam logic [2:0]  GROUP_0       = 3'h0;
	localparam logic [2:0]  GROUP_1       = 3'h1;
	localparam int          GROUP_LSB     = 5;
	localparam int          LUN_LSB       = 5;
	localparam logic [2:0]  LUN_MAX       = 3'h1;
	localparam int          FLAG_BIT      = 1;
	localparam int          LINK_BIT      = 0;

	localparam scdec_byte_t OP_WRITE6     = 8'h0a;
	localparam scdec_byte_t OP_RDCAP      = 8'h25;
	localparam scdec_byte_t OP_READ_EXT   = 8'h28;
	localparam scdec_byte_t OP_SRCH_EQ    = 8'h31;
	localparam scdec_byte_t OP_SRCH_HI    = 8'h30;
	localparam scdec_byte_t OP_SRCH_LO    = 8'h32;
	localparam scdec_byte_t OP_SEEK_EXT   = 8'h2b;
	localparam scdec_byte_t OP_VERIFY     = 8'h2f;
	localparam scdec_byte_t OP_WRITE_EXT  = 8'h2a;
	localparam scdec_byte_t OP_WRITE_VFY  = 8'h2e;

	localparam scdec_byte_t STS_GOOD      = 8'h00;
	localparam scdec_byte_t STS_CHECK     = 8'h02;
	localparam scdec_byte_t STS_INTERMED  = 8'h10;

	localparam logic [3:0]  RCAP_LEN      = 4'h8;
	localparam logic [1:0]  BLK_HI_256    = 2'h1;
	localparam logic [1:0]  BLK_HI_512    = 2'h2;
	localparam logic [8:0]  CNT_ZERO_VAL  = 9'h100;

	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_LASTBLK0  = 8'h04;
	localparam logic [7:0]  REG_LASTBLK1  = 8'h08;
	localparam logic [7:0]  REG_IRQ_STAT  = 8'h0c;
	localparam logic [7:0]  REG_IRQ_MASK  = 8'h10;
	localparam logic [7:0]  REG_LAST_CMD  = 8'h14;
	localparam logic [7:0]  REG_LAST_LBA  = 8'h18;
	localparam logic [7:0]  REG_STATE     = 8'h1c;

	localparam int          CTRL_BLK512   = 0;
	localparam logic [31:0] CTRL_RST      = 32'h0;
	localparam logic [23:0] LASTBLK_RST   = 24'h0;
	localparam int          IRQ_W         = 3;
	localparam int          IRQ_DONE      = 0;
	localparam int          IRQ_ERR       = 1;
	localparam int          IRQ_FLAG      = 2;
endpackage : scdec_pkg

// [verilog/scdec_link_if.sv]
// Byte link between the initiator end and the target end.
// Both ends run on the clock given to the interface.
`timescale 1ns/1ps
interface scdec_link_if (input wire logic clk_sys_i);
	logic       cmd_valid;
	logic       cmd_ready;
	logic [7:0] cmd_byte;
	logic       id_valid;
	logic [2:0] id_lun;
	logic       din_valid;
	logic       din_ready;
	logic [7:0] din_byte;
	logic       sts_valid;
	logic       sts_ready;
	logic [7:0] sts_code;
	logic       intr_req;

	modport target (
		input  cmd_valid, cmd_byte, id_valid, id_lun, din_ready, sts_ready,
		output cmd_ready, din_valid, din_byte, sts_valid, sts_code, intr_req
	);
	modport initiator (
		output cmd_valid, cmd_byte, id_valid, id_lun, din_ready, sts_ready,
		input  cmd_ready, din_valid, din_byte, sts_valid, sts_code, intr_req
	);
endinterface : scdec_link_if

// [verilog/scdec_field_dec.sv]
// Combinational field decoder for a collected command block.
// Assumes byte zero sits in the top byte of the flat input.
`timescale 1ns/1ps
module scdec_field_dec
	import scdec_pkg::*;
(
	// Collected block
	input  wire logic [79:0] cdb_i,
	// Decoded fields
	output logic      [2:0]  group_o,
	output logic      [4:0]  code_o,
	output logic      [2:0]  lun_o,
	output logic      [31:0] lba_o,
	output logic      [8:0]  count_o,
	output logic             flag_o,
	output logic             link_o,
	output logic             known_o,
	output logic             resv_ok_o,
	output logic             rdcap_o
);
	scdec_byte_t b [CDB_MAX];
	scdec_byte_t ctl;
	logic        is_g1;

	always_comb
	begin
		for (int i = 0; i < CDB_MAX; i++)
			b[i] = cdb_i[79 - 8*i -: 8];
	end

	assign group_o = b[0][7:GROUP_LSB];
	assign code_o  = b[0][GROUP_LSB-1:0];
	assign is_g1   = (group_o == GROUP_1);
	assign lun_o   = b[1][7:LUN_LSB];
	assign ctl     = is_g1 ? b[9] : b[5];
	assign flag_o  = ctl[FLAG_BIT];
	assign link_o  = ctl[LINK_BIT];
	assign rdcap_o = (b[0] == OP_RDCAP);

	always_comb
	begin
		unique case (b[0])
			OP_WRITE6, OP_RDCAP, OP_READ_EXT, OP_SRCH_EQ, OP_SRCH_HI, OP_SRCH_LO:
				known_o = 1'b1;
			OP_SEEK_EXT, OP_VERIFY, OP_WRITE_EXT, OP_WRITE_VFY:
				known_o = 1'b1;
			default:
				known_o = 1'b0;
		endcase
	end

	always_comb
	begin
		if (is_g1)
		begin
			lba_o   = {b[2], b[3], b[4], b[5]};
			count_o = {b[7][0], b[8]};
		end
		else
		begin
			lba_o   = {11'h0, b[1][4:0], b[2], b[3]};
			count_o = (b[4] == 8'h00) ? CNT_ZERO_VAL : {1'b0, b[4]};
		end
	end

	// Control byte top bits; the write's top bit is the retry option
	always_comb
	begin
		if (is_g1)
			resv_ok_o = (b[9][7:2] == 6'h0);
		else
			resv_ok_o = (b[5][6:2] == 5'h0);
		if (rdcap_o && (b[1][4:0] != 5'h0 || {b[2], b[3], b[4], b[5], b[6], b[7], b[8]} != 56'h0))
			resv_ok_o = 1'b0;
	end
endmodule : scdec_field_dec

// [verilog/scdec_target.sv]
// Target end: collects command blocks, checks and decodes them, answers
// read capacity, returns status and runs the linked chain.
// Refuses blocks whose control byte or read capacity reserved bytes break the initiator's obligations.
`timescale 1ns/1ps
module scdec_target
	import scdec_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        reset_i,
	// Link
	scdec_link_if.target     link,
	// Register port
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	// Decoded command to the drive side
	output logic             exec_req_o,
	output logic      [7:0]  exec_op_o,
	output logic      [2:0]  exec_lun_o,
	output logic      [31:0] exec_lba_o,
	output logic      [8:0]  exec_count_o,
	// Interrupt
	output logic             irq_o
);
	typedef enum logic [3:0] {
		ST_COLLECT = 4'b0001,
		ST_DECODE  = 4'b0010,
		ST_DATA    = 4'b0100,
		ST_STATUS  = 4'b1000
	} scdec_state_e;

	scdec_state_e state_reg, state_next;
	scdec_byte_t [0:CDB_MAX-1] cdb_reg;
	logic [3:0]   idx_reg, len_reg, rc_idx_reg;
	logic         id_seen_reg, ok_reg, link_reg, flag_reg;
	logic [2:0]   id_lun_reg, lun_eff_reg;
	logic [31:0]  ctrl_reg;
	logic [23:0]  lastblk0_reg, lastblk1_reg;
	logic [IRQ_W-1:0] stat_reg, stat_next, mask_reg, events;
	logic [7:0]   din_reg, sts_reg;
	logic [4:0]   d_code;
	logic [2:0]   d_group, d_lun, lun_eff;
	logic [31:0]  d_lba;
	logic [8:0]   d_count;
	logic         d_flag, d_link, d_known, d_resv_ok, d_rdcap, d_bad;
	logic         cmd_take, last_byte, sts_done, din_take;

	scdec_field_dec i_scdec_field_dec (.cdb_i(cdb_reg), .group_o(d_group), .code_o(d_code),
		.lun_o(d_lun), .lba_o(d_lba), .count_o(d_count), .flag_o(d_flag), .link_o(d_link),
		.known_o(d_known), .resv_ok_o(d_resv_ok), .rdcap_o(d_rdcap));

	function automatic scdec_byte_t rcap_byte(input logic [3:0] i, input logic [23:0] last,
		input logic blk512);
		scdec_byte_t r;
		r = 8'h00;
		unique case (i)
			4'h1: r = last[23:16];
			4'h2: r = last[15:8];
			4'h3: r = last[7:0];
			4'h6: r = {6'h0, blk512 ? BLK_HI_512 : BLK_HI_256};
			default: r = 8'h00;
		endcase
		return r;
	endfunction : rcap_byte

	assign cmd_take  = link.cmd_valid && link.cmd_ready;
	assign last_byte = (idx_reg != 4'h0) && (idx_reg == len_reg - 4'h1);
	assign din_take  = link.din_valid && link.din_ready;
	assign sts_done  = link.sts_valid && link.sts_ready;
	assign lun_eff   = id_seen_reg ? id_lun_reg : d_lun;
	assign d_bad     = !d_known || (lun_eff > LUN_MAX) || !d_resv_ok;

	assign link.cmd_ready = (state_reg == ST_COLLECT);
	assign link.din_valid = (state_reg == ST_DATA);
	assign link.din_byte  = din_reg;
	assign link.sts_valid = (state_reg == ST_STATUS);
	assign link.sts_code  = sts_reg;

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_COLLECT: if (cmd_take && last_byte) state_next = ST_DECODE;
			ST_DECODE:  state_next = (!d_bad && d_rdcap) ? ST_DATA : ST_STATUS;
			ST_DATA:    if (din_take && rc_idx_reg == RCAP_LEN - 4'h1) state_next = ST_STATUS;
			ST_STATUS:  if (sts_done) state_next = ST_COLLECT;
			default:    state_next = ST_COLLECT;
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			state_reg <= ST_COLLECT;
		else
			state_reg <= state_next;
	end

	// Byte collection; length follows the group of byte zero
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			idx_reg <= 4'h0;
			len_reg <= CDB_LEN_G0;
			cdb_reg <= '0;
		end
		else if (cmd_take)
		begin
			cdb_reg[idx_reg] <= link.cmd_byte;
			idx_reg          <= last_byte ? 4'h0 : idx_reg + 4'h1;
			if (idx_reg == 4'h0)
			begin
				len_reg <= (link.cmd_byte[7:GROUP_LSB] == GROUP_1) ? CDB_LEN_G1 : CDB_LEN_G0;
				for (int i = 1; i < CDB_MAX; i++)
					cdb_reg[i] <= 8'h00;
			end
		end
	end

	// Identify LUN holds for the whole linked chain
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			id_seen_reg <= 1'b0;
			id_lun_reg  <= 3'h0;
		end
		else if (link.id_valid)
		begin
			id_seen_reg <= 1'b1;
			id_lun_reg  <= link.id_lun;
		end
		else if (sts_done && !(ok_reg && link_reg))
			id_seen_reg <= 1'b0;
	end

	// Decode outcome, status code and execution request
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			ok_reg       <= 1'b0;
			link_reg     <= 1'b0;
			flag_reg     <= 1'b0;
			lun_eff_reg  <= 3'h0;
			sts_reg      <= STS_GOOD;
			exec_req_o   <= 1'b0;
			exec_op_o    <= 8'h00;
			exec_lun_o   <= 3'h0;
			exec_lba_o   <= 32'h0;
			exec_count_o <= 9'h0;
		end
		else
		begin
			exec_req_o <= 1'b0;
			if (state_reg == ST_DECODE)
			begin
				ok_reg      <= !d_bad;
				link_reg    <= d_link;
				flag_reg    <= d_flag;
				lun_eff_reg <= lun_eff;
				if (d_bad)
					sts_reg <= STS_CHECK;
				else
					sts_reg <= d_link ? STS_INTERMED : STS_GOOD;
				if (!d_bad && !d_rdcap)
				begin
					exec_req_o   <= 1'b1;
					exec_op_o    <= {d_group, d_code};
					exec_lun_o   <= lun_eff;
					exec_lba_o   <= d_lba;
					exec_count_o <= d_count;
				end
			end
		end
	end

	// Read capacity data bytes
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i || state_reg == ST_DECODE)
		begin
			rc_idx_reg <= 4'h0;
			din_reg    <= 8'h00;
		end
		else if (din_take)
		begin
			rc_idx_reg <= rc_idx_reg + 4'h1;
			din_reg    <= rcap_byte(rc_idx_reg + 4'h1, lun_eff_reg[0] ? lastblk1_reg : lastblk0_reg,
				ctrl_reg[CTRL_BLK512]);
		end
	end

	// Interrupt request to the initiator only when Flag and Link both set
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			link.intr_req <= 1'b0;
		else
			link.intr_req <= sts_done && ok_reg && link_reg && flag_reg;
	end

	assign events[IRQ_DONE] = sts_done;
	assign events[IRQ_ERR]  = sts_done && !ok_reg;
	assign events[IRQ_FLAG] = sts_done && ok_reg && link_reg && flag_reg;

	always_comb
	begin
		stat_next = stat_reg;
		if (reg_wr_i && reg_addr_i == REG_IRQ_STAT)
			stat_next = stat_reg & ~reg_wdata_i[IRQ_W-1:0];
		stat_next = stat_next | events;
	end

	// Register writes
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			ctrl_reg     <= CTRL_RST;
			lastblk0_reg <= LASTBLK_RST;
			lastblk1_reg <= LASTBLK_RST;
			mask_reg     <= '0;
			stat_reg     <= '0;
		end
		else
		begin
			stat_reg <= stat_next;
			if (reg_wr_i)
			begin
				unique case (reg_addr_i)
					REG_CTRL:     ctrl_reg     <= reg_wdata_i;
					REG_LASTBLK0: lastblk0_reg <= reg_wdata_i[23:0];
					REG_LASTBLK1: lastblk1_reg <= reg_wdata_i[23:0];
					REG_IRQ_MASK: mask_reg     <= reg_wdata_i[IRQ_W-1:0];
					default:      ;
				endcase
			end
		end
	end

	// Register reads, data one cycle after the strobe
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			reg_rdata_o <= 32'h0;
		else if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				REG_CTRL:     reg_rdata_o <= {31'h0, ctrl_reg[CTRL_BLK512]};
				REG_LASTBLK0: reg_rdata_o <= {8'h0, lastblk0_reg};
				REG_LASTBLK1: reg_rdata_o <= {8'h0, lastblk1_reg};
				REG_IRQ_STAT: reg_rdata_o <= {29'h0, stat_reg};
				REG_IRQ_MASK: reg_rdata_o <= {29'h0, mask_reg};
				REG_LAST_CMD: reg_rdata_o <= {12'h0, exec_count_o, exec_lun_o, exec_op_o};
				REG_LAST_LBA: reg_rdata_o <= exec_lba_o;
				REG_STATE:    reg_rdata_o <= {20'h0, id_seen_reg, link_reg, ok_reg, sts_reg, 1'b0};
				default:      reg_rdata_o <= 32'h0;
			endcase
		end
		else
			reg_rdata_o <= 32'h0;
	end

	assign irq_o = |(stat_reg & mask_reg);
endmodule : scdec_target

// [verilog/scdec_initiator.sv]
// Initiator end: sends a command block byte by byte, then takes data-in
// bytes and the status byte and reports them to its user.
// Assumes one command at a time; start is ignored while busy.
`timescale 1ns/1ps
module scdec_initiator
	import scdec_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        reset_i,
	// Link
	scdec_link_if.initiator  link,
	// User request
	input  wire logic        start_i,
	input  wire logic [79:0] cdb_i,
	input  wire logic        id_valid_i,
	input  wire logic [2:0]  id_lun_i,
	// User answers
	output logic             busy_o,
	output logic             din_valid_o,
	output logic      [7:0]  din_byte_o,
	output logic             sts_valid_o,
	output logic      [7:0]  sts_code_o,
	output logic             intr_o
);
	typedef enum logic [2:0] {
		HS_IDLE = 3'b001,
		HS_SEND = 3'b010,
		HS_WAIT = 3'b100
	} scdec_hstate_e;

	scdec_hstate_e state_reg;
	scdec_byte_t   cdb_reg [CDB_MAX];
	logic [3:0]    idx_reg, len_reg;
	scdec_byte_t   b0;
	logic          rdcap;

	assign b0    = cdb_i[79:72];
	assign rdcap = (b0 == OP_RDCAP);

	assign link.cmd_valid = (state_reg == HS_SEND);
	assign link.cmd_byte  = cdb_reg[idx_reg];
	assign link.din_ready = 1'b1;
	assign link.sts_ready = (state_reg == HS_WAIT);
	assign busy_o         = (state_reg != HS_IDLE);

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			link.id_valid <= 1'b0;
			link.id_lun   <= 3'h0;
		end
		else
		begin
			link.id_valid <= id_valid_i;
			link.id_lun   <= id_lun_i;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			state_reg <= HS_IDLE;
			idx_reg   <= 4'h0;
			len_reg   <= CDB_LEN_G0;
			for (int i = 0; i < CDB_MAX; i++)
				cdb_reg[i] <= 8'h00;
		end
		else
		begin
			unique case (state_reg)
				HS_IDLE:
					if (start_i)
					begin
						for (int i = 0; i < CDB_MAX; i++)
							cdb_reg[i] <= cdb_i[79 - 8*i -: 8];
						if (rdcap)
						begin
							cdb_reg[1] <= {cdb_i[71:69], 5'h0};
							for (int i = 2; i < CDB_MAX - 1; i++)
								cdb_reg[i] <= 8'h00;
						end
						if (b0[7:GROUP_LSB] == GROUP_1)
						begin
							len_reg    <= CDB_LEN_G1;
							cdb_reg[9] <= {6'h0, cdb_i[1:0]};
						end
						else
						begin
							len_reg    <= CDB_LEN_G0;
							cdb_reg[5] <= {cdb_i[39], 5'h0, cdb_i[33:32]};
						end
						idx_reg   <= 4'h0;
						state_reg <= HS_SEND;
					end
				HS_SEND:
					if (link.cmd_ready)
					begin
						if (idx_reg == len_reg - 4'h1)
							state_reg <= HS_WAIT;
						else
							idx_reg <= idx_reg + 4'h1;
					end
				HS_WAIT:
					if (link.sts_valid)
						state_reg <= HS_IDLE;
				default:
					state_reg <= HS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			din_valid_o <= 1'b0;
			din_byte_o  <= 8'h00;
			sts_valid_o <= 1'b0;
			sts_code_o  <= 8'h00;
			intr_o      <= 1'b0;
		end
		else
		begin
			din_valid_o <= link.din_valid;
			sts_valid_o <= link.sts_valid && state_reg == HS_WAIT;
			intr_o      <= link.intr_req;
			if (link.din_valid)
				din_byte_o <= link.din_byte;
			if (link.sts_valid && state_reg == HS_WAIT)
				sts_code_o <= link.sts_code;
		end
	end
endmodule : scdec_initiator

// [verif/scdec_assertions.sv]
// Concurrent checks on the link between initiator and target.
// Takes the link signals as plain inputs, instantiated beside the link.
`timescale 1ns/1ps
module scdec_assertions
	import scdec_pkg::*;
(
	// Clock and reset
	input wire logic       clk_sys_i,
	input wire logic       reset_i,
	// Command side
	input wire logic       cmd_valid,
	input wire logic       cmd_ready,
	input wire logic [7:0] cmd_byte,
	input wire logic       id_valid,
	input wire logic [2:0] id_lun,
	// Answer side
	input wire logic       din_valid,
	input wire logic       din_ready,
	input wire logic [7:0] din_byte,
	input wire logic       sts_valid,
	input wire logic       sts_ready,
	input wire logic [7:0] sts_code,
	input wire logic       intr_req
);
	logic [3:0] cnt_reg, len_reg, len_now;
	logic [7:0] op_reg, ctl_reg;
	logic [2:0] lun_reg, idl_reg;
	logic       id_reg, last_take, done, bad;

	assign len_now   = (cnt_reg != 4'h0) ? len_reg :
		((cmd_byte[7:5] == GROUP_1) ? CDB_LEN_G1 : CDB_LEN_G0);
	assign last_take = cmd_valid && cmd_ready && (cnt_reg == len_now - 4'h1);
	assign done      = sts_valid && sts_ready;
	assign bad       = !(op_reg inside {OP_WRITE6, OP_RDCAP, OP_READ_EXT, OP_SRCH_EQ,
		OP_SRCH_HI, OP_SRCH_LO, OP_SEEK_EXT, OP_VERIFY, OP_WRITE_EXT, OP_WRITE_VFY})
		|| ((id_reg ? idl_reg : lun_reg) > LUN_MAX)
		|| ((op_reg[7:5] == GROUP_1) ? |ctl_reg[7:2] : |ctl_reg[6:2]);

	// Byte count within a block
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			cnt_reg <= 4'h0;
		else if (cmd_valid && cmd_ready)
			cnt_reg <= last_take ? 4'h0 : cnt_reg + 4'h1;
	end

	// Fields of the block just taken
	always_ff @(posedge clk_sys_i)
	begin
		if (cmd_valid && cmd_ready && cnt_reg == 4'h0)
		begin
			len_reg <= len_now;
			op_reg  <= cmd_byte;
		end
		if (cmd_valid && cmd_ready && cnt_reg == 4'h1)
			lun_reg <= cmd_byte[7:5];
		if (last_take)
			ctl_reg <= cmd_byte;
	end

	// Identify unit, held until a closing status
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			id_reg <= 1'b0;
		else if (id_valid)
			id_reg <= 1'b1;
		else if (done && sts_code != STS_INTERMED)
			id_reg <= 1'b0;
		if (id_valid)
			idl_reg <= id_lun;
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	a_rdcap_burst: assert property ($rose(din_valid) |-> din_valid [*8] ##1 !din_valid)
		else $error("capacity burst length wrong");
	a_rdcap_zeros: assert property ($rose(din_valid) |->
		din_byte == 8'h00 ##4 din_byte == 8'h00 ##1 din_byte == 8'h00)
		else $error("capacity zero bytes wrong");
	a_rdcap_size: assert property ($rose(din_valid) |-> ##6 (din_byte == {6'h0, BLK_HI_256}
		|| din_byte == {6'h0, BLK_HI_512}) ##1 din_byte == 8'h00)
		else $error("capacity block size wrong");
	a_rdcap_cause: assert property ($rose(din_valid) |-> op_reg == OP_RDCAP && !bad)
		else $error("data sent without capacity command");
	a_answer_time: assert property (last_take |-> ##2 (sts_valid || din_valid))
		else $error("no answer two cycles after block");
	a_collect_only: assert property ((din_valid || sts_valid) |-> !cmd_ready)
		else $error("bytes taken while answering");
	a_flag_intr: assert property (done && sts_code == STS_INTERMED && ctl_reg[FLAG_BIT]
		|=> intr_req)
		else $error("missing interrupt request");
	a_flag_quiet: assert property (done && !(sts_code == STS_INTERMED && ctl_reg[FLAG_BIT])
		|=> !intr_req)
		else $error("stray interrupt request");
	a_link_code: assert property (sts_valid && sts_code != STS_CHECK |->
		sts_code == (ctl_reg[LINK_BIT] ? STS_INTERMED : STS_GOOD))
		else $error("status code ignores link");
	a_bad_block: assert property (sts_valid && bad |-> sts_code == STS_CHECK)
		else $error("bad block not refused");
	a_good_block: assert property (sts_valid && !bad && op_reg != OP_RDCAP
		|-> sts_code != STS_CHECK)
		else $error("good block refused");
endmodule : scdec_assertions

// [verif/test_scsi_group1_cdb_decoder.sv]
// Bench: initiator and target joined by the link, plus a second target
// fed by a raw driver. Assumes package and link interface compiled first.
`timescale 1ns/1ps
module test_scsi_group1_cdb_decoder
	import scdec_pkg::*;
;
	logic        clk_sys_i, reset_i, start_i, id_valid_i, reg_wr_i, reg_rd_i;
	logic        exec_req_o, irq_o, busy_o, din_valid_o, sts_valid_o, intr_o;
	logic        ex_seen, blk512, held;
	logic [2:0]  id_lun_i, exec_lun_o, ex_lun, held_lun;
	logic [7:0]  reg_addr_i, exec_op_o, din_byte_o, sts_code_o, ex_op;
	logic [8:0]  exec_count_o, ex_cnt;
	logic [31:0] reg_wdata_i, reg_rdata_o, exec_lba_o, ex_lba, rd, r;
	logic [79:0] cdb_i;
	logic [23:0] last_blk [2];
	scdec_byte_t ops [8];
	int          failures, comparisons, cycles, seed;

	scdec_link_if link (.clk_sys_i(clk_sys_i));
	scdec_link_if link2 (.clk_sys_i(clk_sys_i));
	scdec_target i_scdec_target (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .link(link),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .exec_req_o(exec_req_o),
		.exec_op_o(exec_op_o), .exec_lun_o(exec_lun_o), .exec_lba_o(exec_lba_o),
		.exec_count_o(exec_count_o), .irq_o(irq_o));
	scdec_target i_scdec_target_raw (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .link(link2),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(), .exec_req_o(), .exec_op_o(), .exec_lun_o(),
		.exec_lba_o(), .exec_count_o(), .irq_o());
	scdec_initiator i_scdec_initiator (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .link(link),
		.start_i(start_i), .cdb_i(cdb_i), .id_valid_i(id_valid_i), .id_lun_i(id_lun_i),
		.busy_o(busy_o), .din_valid_o(din_valid_o), .din_byte_o(din_byte_o),
		.sts_valid_o(sts_valid_o), .sts_code_o(sts_code_o), .intr_o(intr_o));
	scdec_assertions i_scdec_assertions (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready), .cmd_byte(link.cmd_byte),
		.id_valid(link.id_valid), .id_lun(link.id_lun), .din_valid(link.din_valid),
		.din_ready(link.din_ready), .din_byte(link.din_byte), .sts_valid(link.sts_valid),
		.sts_ready(link.sts_ready), .sts_code(link.sts_code), .intr_req(link.intr_req));

	initial
	begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run();
		if (failures == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1;
		rd = reg_rdata_o;
	endtask : reg_rd

	// Send one block through the initiator and compare with the model
	task automatic run_cmd(input logic [79:0] blk, input logic idv, input logic [2:0] idl);
		scdec_byte_t b [10];
		scdec_byte_t dq [$];
		scdec_byte_t eq [$];
		scdec_byte_t ctl, sts;
		logic [2:0]  lun;
		logic        ok, ic;
		int          n;
		for (int i = 0; i < 10; i++)
			b[i] = blk[79 - 8 * i -: 8];
		ctl = (b[0][7:5] == GROUP_1) ? b[9] : b[5];
		if (idv)
		begin
			held     = 1'b1;
			held_lun = idl;
		end
		lun = held ? held_lun : b[1][7:5];
		ok  = (b[0] inside {OP_WRITE6, OP_RDCAP, OP_READ_EXT, OP_SRCH_EQ, OP_SRCH_HI,
			OP_SRCH_LO, OP_SEEK_EXT, OP_VERIFY, OP_WRITE_EXT, OP_WRITE_VFY}) && lun <= LUN_MAX;
		sts = !ok ? STS_CHECK : (ctl[LINK_BIT] ? STS_INTERMED : STS_GOOD);
		if (ok && b[0] == OP_RDCAP)
			eq = '{8'h00, last_blk[lun[0]][23:16], last_blk[lun[0]][15:8], last_blk[lun[0]][7:0],
				8'h00, 8'h00, {6'h0, blk512 ? BLK_HI_512 : BLK_HI_256}, 8'h00};
		ex_seen = 1'b0;
		ic      = 1'b0;
		n       = 0;
		@(posedge clk_sys_i);
		start_i    <= 1'b1;
		cdb_i      <= blk;
		id_valid_i <= idv;
		id_lun_i   <= idl;
		@(posedge clk_sys_i);
		start_i    <= 1'b0;
		id_valid_i <= 1'b0;
		do
		begin
			@(posedge clk_sys_i);
			n++;
			if (n == 1)
				check(32'(busy_o), 32'h1);
			if (din_valid_o === 1'b1)
				dq.push_back(din_byte_o);
		end
		while (sts_valid_o !== 1'b1 && n < 100);
		check(32'(sts_code_o), 32'(sts));
		repeat (4)
		begin
			@(posedge clk_sys_i);
			ic = ic | (intr_o === 1'b1);
		end
		check(32'(ic), 32'(ok && ctl[FLAG_BIT] && ctl[LINK_BIT]));
		check(32'(dq.size()), 32'(eq.size()));
		foreach (eq[i])
			check(32'(dq[i]), 32'(eq[i]));
		check(32'(ex_seen), 32'(ok && b[0] != OP_RDCAP));
		if (ex_seen === 1'b1)
			check({21'h0, ex_lun, ex_op}, {21'h0, lun, b[0]});
		if (ex_seen === 1'b1 && b[0] == OP_WRITE6)
		begin
			check(ex_lba, {11'h0, b[1][4:0], b[2], b[3]});
			check(32'(ex_cnt), (b[4] == 8'h00) ? 32'(CNT_ZERO_VAL) : 32'(b[4]));
		end
		if (sts != STS_INTERMED)
			held = 1'b0;
	endtask : run_cmd

	// Raw bytes to the second target, status always accepted
	task automatic raw_cmd(input logic [79:0] blk, input int len, input scdec_byte_t sts);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		for (int i = 0; i < len; i++)
		begin
			link2.cmd_valid <= 1'b1;
			link2.cmd_byte  <= blk[79 - 8 * i -: 8];
			do
				@(posedge clk_sys_i);
			while (link2.cmd_ready !== 1'b1);
		end
		link2.cmd_valid <= 1'b0;
		link2.cmd_byte  <= ~blk[87 - 8 * len -: 8];
		do
		begin
			@(posedge clk_sys_i);
			n++;
		end
		while (link2.sts_valid !== 1'b1 && n < 100);
		check(32'(link2.sts_code), 32'(sts));
	endtask : raw_cmd

	always @(posedge clk_sys_i)
	begin
		if (exec_req_o === 1'b1)
		begin
			ex_seen = 1'b1;
			ex_op   = exec_op_o;
			ex_lun  = exec_lun_o;
			ex_lba  = exec_lba_o;
			ex_cnt  = exec_count_o;
		end
	end

	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			failures++;
			complete_run();
		end
	end

	initial
	begin
		{reset_i, link2.sts_ready, link2.din_ready} = 3'h7;
		{start_i, id_valid_i, id_lun_i, cdb_i, reg_wr_i, reg_rd_i} = '0;
		{reg_addr_i, reg_wdata_i, link2.cmd_valid, link2.cmd_byte} = '0;
		{link2.id_valid, link2.id_lun, held, blk512} = '0;
		{failures, comparisons, cycles} = '0;
		seed = 32'h2cb579fc;
		ops  = '{OP_READ_EXT, OP_SRCH_EQ, OP_SRCH_HI, OP_SRCH_LO, OP_SEEK_EXT, OP_VERIFY,
			OP_WRITE_EXT, OP_WRITE_VFY};
		repeat (8) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		reg_rd(REG_CTRL);
		check(rd, CTRL_RST);
		reg_rd(8'h40);
		check(rd, 32'h0);
		for (int k = 0; k < 2; k++)
		begin
			last_blk[k] = 24'($random(seed));
			reg_wr(k ? REG_LASTBLK1 : REG_LASTBLK0, {8'h00, last_blk[k]});
		end
		reg_wr(8'h44, 32'hffffffff);
		reg_rd(REG_LASTBLK1);
		check(rd, {8'h00, last_blk[1]});
		// Capacity for both units and sizes, chaining flags
		for (int k = 0; k < 4; k++)
		begin
			blk512 = k[0];
			reg_wr(REG_CTRL, {31'h0, blk512});
			run_cmd({OP_RDCAP, 2'h0, k[1], 67'h0, k[1:0]}, 1'b0, 3'h0);
		end
		for (int k = 0; k < 3; k++)
		begin
			r = $random(seed);
			run_cmd({OP_WRITE6, 2'h0, k[0], r[20:0], (k == 0) ? 8'h00 : r[28:21], 6'h0,
				r[30:29], 32'h0}, 1'b0, 3'h0);
		end
		reg_rd(REG_LAST_LBA);
		check(rd, {11'h0, r[20:0]});
		foreach (ops[k])
		begin
			r = $random(seed);
			run_cmd({ops[k], 8'h00, r, 24'h0, 6'h0, r[31:30]}, 1'b0, 3'h0);
		end
		// Refused blocks and identify override
		run_cmd({8'h27, 72'h0}, 1'b0, 3'h0);
		run_cmd({8'h08, 72'h0}, 1'b0, 3'h0);
		run_cmd({OP_RDCAP, 3'h2, 69'h0}, 1'b0, 3'h0);
		run_cmd({OP_RDCAP, 3'h3, 69'h0}, 1'b1, 3'h1);
		run_cmd({OP_WRITE6, 72'h0}, 1'b1, 3'h2);
		// Status bits, mask and level output
		reg_wr(REG_IRQ_STAT, 32'h7);
		reg_wr(REG_IRQ_MASK, 32'h2);
		run_cmd({8'h27, 72'h0}, 1'b0, 3'h0);
		check(32'(irq_o), 32'h1);
		reg_wr(REG_IRQ_STAT, 32'h2);
		check(32'(irq_o), 32'h0);
		reg_wr(REG_IRQ_MASK, 32'h0);
		run_cmd({OP_WRITE6, 32'h0, 8'h03, 32'h0}, 1'b0, 3'h0);
		reg_rd(REG_IRQ_STAT);
		check(32'(rd[2:0]), 32'h5);
		check(32'(irq_o), 32'h0);
		reg_wr(REG_IRQ_MASK, 32'h4);
		check(32'(irq_o), 32'h1);
		reg_wr(REG_IRQ_STAT, 32'h5);
		check(32'(irq_o), 32'h0);
		// Initiator duties broken, then two legal blocks, on the second target
		raw_cmd({OP_RDCAP, 64'h0, 8'h04}, 10, STS_CHECK);
		raw_cmd({OP_RDCAP, 8'h01, 64'h0}, 10, STS_CHECK);
		raw_cmd({OP_RDCAP, 16'h0, 8'h5a, 48'h0}, 10, STS_CHECK);
		raw_cmd({OP_WRITE6, 32'h0, 8'h40, 32'h0}, 6, STS_CHECK);
		raw_cmd({OP_WRITE6, 32'h0, 8'h82, 32'h0}, 6, STS_GOOD);
		raw_cmd({OP_RDCAP, 8'h20, 64'h0}, 10, STS_GOOD);
		complete_run();
	end
endmodule : test_scsi_group1_cdb_decoder
